// ---- bench/osr_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Host side of the register port, one request per wr or rd call.
// ----------------------------------------------------------------------------
module osr_host_model (
  input  wire logic                clock_i,
  output osr_pkg::osr_addr_t       addr_o,
  output logic                     wr_o,
  output osr_pkg::osr_word_t       wdata_o,
  output logic                     rd_o,
  input  wire osr_pkg::osr_word_t  rdata_i,
  input  wire logic                rvalid_i
);
  import osr_pkg::*;

  // Idle request lines from time zero.
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end

  // One write; data turns over once released so stale data never matches.
  task automatic wr(input osr_addr_t a, input osr_word_t d);
    @(posedge clock_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr

  // One read; the answer is awaited for a bounded number of cycles.
  task automatic rd(input osr_addr_t a, output osr_word_t d);
    int n = 0;
    @(posedge clock_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    // A missing answer returns inverted data, so it cannot pass a compare.
    d = (rvalid_i === 1'b1) ? rdata_i : ~rdata_i;
  endtask : rd

  // Reserved words get their mandated contents, the reset defaults.
  task automatic init_reserved();
    wr(OFS_TIMER, 16'h000f);
    wr(OFS_CONV_A, 16'h1010);
    wr(OFS_CONV_B, 16'h004c);
  endtask : init_reserved
endmodule : osr_host_model

// ---- bench/tb.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Self-checking bench of the register map.
// ----------------------------------------------------------------------------
module tb;
  import osr_pkg::*;
  logic               clock_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic               slot_end_i, soft_reset_o, fb_200k_o, fb_100k_o;
  logic               fb_50k_o, pole_low_100k_o, pole_high_300k_o;
  logic               osc_fast_i = 1'b0;
  logic               osc_slow_i = 1'b0;
  logic [1:0]         amp_reference_select_o;
  osr_addr_t          reg_addr_i;
  osr_word_t          reg_wdata_i, reg_rdata_o, w;
  osr_word_t          timer_cfg_o, conv_a_cfg_o, conv_b_cfg_o;
  osr_word_t          want [RESULT_COUNT];
  osr_raw_t           slot_raw_i [RESULT_COUNT];
  logic [15:0]        seed = 16'h99f6;  // 39414.
  int                 n_mismatch = 0;
  int                 checked = 0;
  int                 cyc = 0;

  // Identity parameters take arbitrary values of our own.
  osr_register_map #(.PART_ID(12'h3c3), .VERSION(4'h2)) uut (
    .clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .slot_end_i, .slot_raw_i, .osc_fast_i,
    .osc_slow_i, .soft_reset_o, .fb_200k_o, .fb_100k_o, .fb_50k_o,
    .pole_low_100k_o, .pole_high_300k_o, .amp_reference_select_o,
    .timer_cfg_o, .conv_a_cfg_o, .conv_b_cfg_o);
  osr_host_model host (.clock_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i),
    .wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o));

  initial clock_i = 1'b0;
  always #4 clock_i = ~clock_i;

  // Oscillators are phase locked to the clock so that fast and slow rises
  // never share a cycle: two slow periods hold exactly 512 fast rises.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 0) osc_fast_i <= ~osc_fast_i;
    if (cyc % 512 == 1) osc_slow_i <= ~osc_slow_i;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Word expected at an offset after any reset.
  function automatic osr_word_t rst_val(input osr_addr_t a);
    case (a)
      8'h07: return 16'h0020;
      8'h08: return 16'h23c3;
      8'h09: return 16'h0064;
      8'h0c: return 16'h000f;
      8'h10: return 16'h1010;
      8'h11: return 16'h004c;
      8'h12: return 16'h1c08;
      default: return 16'h0000;
    endcase
  endfunction : rst_val

  // Gain one-hot then pole pair, from a trim code of pole and gain.
  function automatic logic [4:0] dec(input logic [3:0] c);
    return {c[1:0] == 2'h0, c[1:0] == 2'h1, c[1], c[3], c[2]};
  endfunction : dec

  task automatic chk_w(input osr_word_t got, input osr_word_t exp_v);
    checked++;
    if (got !== exp_v) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp_v);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp_v);
    chk_w({15'h0000, got}, {15'h0000, exp_v});
  endtask : chk_b

  task automatic check_all();
    for (int i = 0; i < 20; i++) begin
      host.rd(8'(i), w);
      chk_w(w, rst_val(8'(i)));
    end
  endtask : check_all

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    slot_end_i = 1'b0;
    foreach (slot_raw_i[i]) slot_raw_i[i] = '0;
    repeat (5) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    check_all();
    chk_w({11'h000, fb_200k_o, fb_100k_o, fb_50k_o, pole_low_100k_o,
           pole_high_300k_o}, {11'h000, dec(4'h8)});
    // Every gain and pole code, reference bits drawn at random.
    for (int c = 0; c < 16; c++) begin
      seed = lfsr(seed);
      host.wr(OFS_TRIM, {10'h070, seed[1:0], 4'(c)});
      @(posedge clock_i);
      #1;
      chk_w({11'h000, fb_200k_o, fb_100k_o, fb_50k_o, pole_low_100k_o,
             pole_high_300k_o}, {11'h000, dec(4'(c))});
      chk_w({14'h0000, amp_reference_select_o}, {14'h0000, seed[1:0]});
    end
    // Random results with clipping corners; raw inputs turn over after the
    // pulse so that only the pulse edge can load them.
    for (int r = 0; r < 3; r++) begin
      foreach (slot_raw_i[i]) begin
        seed = lfsr(seed);
        slot_raw_i[i] = {seed[3], seed};
      end
      if (r == 0) slot_raw_i[0] = 17'h10000;
      if (r == 0) slot_raw_i[1] = 17'h0ffff;
      foreach (want[i]) want[i] = slot_raw_i[i][16] ? 16'hffff
                                                    : slot_raw_i[i][15:0];
      @(posedge clock_i);
      #1;
      slot_end_i = 1'b1;
      @(posedge clock_i);
      #1;
      slot_end_i = 1'b0;
      foreach (slot_raw_i[i]) slot_raw_i[i] = ~slot_raw_i[i];
      host.wr(8'(r), 16'h1234);
      for (int i = 0; i < 7; i++) begin
        host.rd(8'(i), w);
        chk_w(w, want[i]);
      end
    end
    seed = lfsr(seed);
    host.wr(OFS_TIMER, seed);
    chk_w(timer_cfg_o, seed);
    host.init_reserved();
    chk_w({timer_cfg_o ^ 16'h000f, conv_a_cfg_o ^ 16'h1010},
          {conv_b_cfg_o ^ 16'h004c, 16'h0000});
    while (cyc < 5000) @(posedge clock_i);
    #1;
    host.rd(OFS_OSC_CAL, w);
    chk_w(w, 16'h0200);
    host.wr(OFS_TRIM, 16'h1c3d);
    host.wr(OFS_SOFT_RST, 16'h0001);
    chk_b(soft_reset_o, 1'b1);
    @(posedge clock_i);
    #1;
    chk_b(soft_reset_o, 1'b0);
    check_all();
    chk_b(fb_200k_o, 1'b1);
    close_out();
  end
endmodule : tb

// ---- verilog/osr_osc_counter.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Counts fast clock edges across two slow oscillator periods.
// ----------------------------------------------------------------------------
module osr_osc_counter (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic        fast_i,
  input  wire logic        slow_i,
  output logic [11:0]      count_o
);
  import osr_pkg::*;

  logic [1:0]  fast_sync_reg;   // Two-stage synchroniser, fast clock.
  logic [1:0]  slow_sync_reg;   // Two-stage synchroniser, slow clock.
  logic        fast_last_reg;   // Previous synchronised fast level.
  logic        slow_last_reg;   // Previous synchronised slow level.
  logic [1:0]  phase_reg;       // Slow edges seen in the window.
  logic [11:0] run_reg;         // Running count.
  logic        fast_rise;
  logic        slow_rise;

  // Only stage two of each synchroniser feeds the edge detectors. All
  // stages reset high: a pin that is already high at release then gives
  // no false rise, which would open a short first window.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fast_sync_reg <= 2'h3;
      slow_sync_reg <= 2'h3;
      fast_last_reg <= 1'b1;
      slow_last_reg <= 1'b1;
    end else begin
      fast_sync_reg <= {fast_sync_reg[0], fast_i};
      slow_sync_reg <= {slow_sync_reg[0], slow_i};
      fast_last_reg <= fast_sync_reg[1];
      slow_last_reg <= slow_sync_reg[1];
    end
  end

  assign fast_rise = fast_sync_reg[1] & ~fast_last_reg;
  assign slow_rise = slow_sync_reg[1] & ~slow_last_reg;

  // Window phase: 0 waits for a first edge, 1 and 2 are inside the window.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else if (clear_i) begin
      phase_reg <= 2'h0;
    end else if (slow_rise) begin
      phase_reg <= (phase_reg == OSC_LAST_PER) ? 2'h1 : phase_reg + 2'h1;
    end
  end

  // The count stops at full scale so a slow oscillator never wraps it.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run_reg <= OSC_CAL_RST;
    end else if (clear_i || (slow_rise && phase_reg != 2'h1)) begin
      run_reg <= OSC_CAL_RST;
    end else if (phase_reg != 2'h0 && fast_rise && run_reg != OSC_CAL_MAX) begin
      run_reg <= run_reg + 12'h001;                            // see R05
    end
  end

  // The result is published at the edge that closes the second period.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= OSC_CAL_RST;
    end else if (clear_i) begin
      count_o <= OSC_CAL_RST;
    end else if (slow_rise && phase_reg == OSC_LAST_PER) begin
      count_o <= run_reg;                                      // see R05
    end
  end

  cal_publish_a: assert property (@(posedge clock_i) disable iff (rst_i)
    slow_rise && !clear_i && phase_reg == OSC_LAST_PER |=>
      count_o == $past(run_reg))                               // see R05
    else $error("Calibration count not published at window end.");

endmodule : osr_osc_counter

// ---- verilog/osr_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants of the optical sensor low register map.
// ----------------------------------------------------------------------------
package osr_pkg;

  // Data word, raw result and register address types.
  typedef logic [15:0] osr_word_t;
  typedef logic [16:0] osr_raw_t;
  typedef logic [7:0]  osr_addr_t;

  // Number of result registers updated together at a slot end.
  localparam int RESULT_COUNT = 7;

  // Register offsets.
  localparam osr_addr_t OFS_GEST_X1   = 8'h00;
  localparam osr_addr_t OFS_GEST_X2   = 8'h01;
  localparam osr_addr_t OFS_GEST_Y1   = 8'h02;
  localparam osr_addr_t OFS_GEST_Y2   = 8'h03;
  localparam osr_addr_t OFS_PROX_I    = 8'h04;
  localparam osr_addr_t OFS_PROX_X    = 8'h05;
  localparam osr_addr_t OFS_PROX_Y    = 8'h06;
  localparam osr_addr_t OFS_RESERVED7 = 8'h07;
  localparam osr_addr_t OFS_IDENT     = 8'h08;
  localparam osr_addr_t OFS_BUS_ADDR  = 8'h09;
  localparam osr_addr_t OFS_OSC_CAL   = 8'h0a;
  localparam osr_addr_t OFS_TIMER     = 8'h0c;
  localparam osr_addr_t OFS_SOFT_RST  = 8'h0f;
  localparam osr_addr_t OFS_CONV_A    = 8'h10;
  localparam osr_addr_t OFS_CONV_B    = 8'h11;
  localparam osr_addr_t OFS_TRIM      = 8'h12;

  // Values after reset, and the result full scale.
  localparam osr_word_t RST_RESULT    = 16'h0000;
  localparam osr_word_t RST_RESERVED7 = 16'h0020;
  localparam osr_word_t RST_TIMER     = 16'h000f;
  localparam osr_word_t RST_CONV_A    = 16'h1010;
  localparam osr_word_t RST_CONV_B    = 16'h004c;
  localparam osr_word_t RST_TRIM      = 16'h1c08;
  localparam osr_word_t RESULT_MAX    = 16'hffff;

  // Bus address as an eight-bit write address; the field holds bits 7:1.
  localparam logic [7:0] BUS_ADDR_WIRE = 8'hc8;

  // Field positions.
  localparam int SOFT_RST_BIT = 0;
  localparam int GAIN_LSB     = 0;
  localparam int POLE_LSB     = 2;
  localparam int VREF_LSB     = 4;

  // Gain select codes.
  localparam logic [1:0] GAIN_200K = 2'h0;
  localparam logic [1:0] GAIN_100K = 2'h1;

  // Oscillator calibration counter limits.
  localparam logic [11:0] OSC_CAL_MAX  = 12'hfff;
  localparam logic [11:0] OSC_CAL_RST  = 12'h000;
  localparam logic [1:0]  OSC_LAST_PER = 2'h2;

endpackage : osr_pkg

// ---- verilog/osr_register_map.sv ----
`timescale 1ns/1ns
// How it works
// R01 - Four gesture results at 0x00, reset zero.
// R02 - Three proximity results at 0x04..0x06, reset zero.
// R03 - Identity word at 0x08, never reset.
// R04 - Own bus address at 0x09, never reset.
// R05 - Fast cycles over two slow periods, 0x0A.
// R06 - Writing one to 0x0F bit0 resets.
// R07 - Gain code selects 200k, 100k, 50k.
// R08 - Pole code selects four band-pass pole pairs.
// R09 - Host writes mandated values to reserved words.
// R10 - Read-only word 0x07 reads 0x20.
// R11 - Results update together, clipping at maximum.
// R12 - Soft reset bit clears itself after use.
module osr_register_map #(
  parameter logic [11:0] PART_ID = 12'h5a5,   // Arbitrary value.
  parameter logic [3:0]  VERSION = 4'h1       // Arbitrary value.
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire osr_pkg::osr_addr_t  reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire osr_pkg::osr_word_t  reg_wdata_i,
  input  wire logic                reg_rd_i,
  output osr_pkg::osr_word_t       reg_rdata_o,
  output logic                     reg_rvalid_o,
  input  wire logic                slot_end_i,
  input  wire osr_pkg::osr_raw_t   slot_raw_i [osr_pkg::RESULT_COUNT],
  input  wire logic                osc_fast_i,
  input  wire logic                osc_slow_i,
  output logic                     soft_reset_o,
  output logic                     fb_200k_o,
  output logic                     fb_100k_o,
  output logic                     fb_50k_o,
  output logic                     pole_low_100k_o,
  output logic                     pole_high_300k_o,
  output logic [1:0]               amp_reference_select_o,
  output osr_pkg::osr_word_t       timer_cfg_o,
  output osr_pkg::osr_word_t       conv_a_cfg_o,
  output osr_pkg::osr_word_t       conv_b_cfg_o
);
  import osr_pkg::*;

  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------

  logic        soft_reset_reg;   // Self-clearing soft reset bit.
  osr_word_t   timer_reg;        // Timer test word.
  osr_word_t   conv_a_reg;       // First converter word.
  osr_word_t   conv_b_reg;       // Second converter word.
  osr_word_t   trim_reg;         // Front-end trim word.
  osr_word_t   read_next;        // Value selected for the current read.
  logic [11:0] osc_count;        // Published calibration count.
  logic [1:0]  amp_gain_select;  // Feedback resistor code.
  logic [1:0]  bandpass_pole_select; // Pole pair code.
  logic        soft_hit;         // Write that requests a soft reset.

  osr_result_if rif ();          // Result path to the bank.

  // --------------------------------------------------------------------------
  // Result bank and calibration counter.
  // --------------------------------------------------------------------------

  // The sampling engine runs on this clock, so its strobe is used directly.
  assign rif.slot_end = slot_end_i;
  assign rif.raw      = slot_raw_i;
  assign rif.clear    = soft_reset_reg;

  osr_result_bank u_bank (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .rif     (rif.bank)
  );

  // Both oscillators come from outside this clock and are resynchronised
  // inside the counter.
  osr_osc_counter u_osc (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .clear_i (soft_reset_reg),
    .fast_i  (osc_fast_i),
    .slow_i  (osc_slow_i),
    .count_o (osc_count)
  );

  // --------------------------------------------------------------------------
  // Soft reset.
  // --------------------------------------------------------------------------

  assign soft_hit = reg_wr_i && (reg_addr_i == OFS_SOFT_RST)
                    && reg_wdata_i[SOFT_RST_BIT];

  // The bit stays high for one cycle and then drops by itself, so a later
  // read returns zero. A new request in the clearing cycle wins.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_reg <= 1'b0;
    end else if (soft_hit) begin
      soft_reset_reg <= 1'b1;                                  // see R06
    end else begin
      soft_reset_reg <= 1'b0;                                  // see R12
    end
  end

  assign soft_reset_o = soft_reset_reg;

  // --------------------------------------------------------------------------
  // Writable words.
  // --------------------------------------------------------------------------

  // The reserved words simply hold what the host writes; the host is
  // trusted to write the mandated values (see R09). A soft reset returns
  // them to their defaults and a write in that cycle is dropped.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reg <= RST_TIMER;
    end else if (soft_reset_reg) begin
      timer_reg <= RST_TIMER;                                  // see R06
    end else if (reg_wr_i && reg_addr_i == OFS_TIMER) begin
      timer_reg <= reg_wdata_i;
    end
  end

  // First converter word.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      conv_a_reg <= RST_CONV_A;
    end else if (soft_reset_reg) begin
      conv_a_reg <= RST_CONV_A;                                // see R06
    end else if (reg_wr_i && reg_addr_i == OFS_CONV_A) begin
      conv_a_reg <= reg_wdata_i;
    end
  end

  // Second converter word.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      conv_b_reg <= RST_CONV_B;
    end else if (soft_reset_reg) begin
      conv_b_reg <= RST_CONV_B;                                // see R06
    end else if (reg_wr_i && reg_addr_i == OFS_CONV_B) begin
      conv_b_reg <= reg_wdata_i;
    end
  end

  // Front-end trim word; its upper fields are kept for the next stages.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      trim_reg <= RST_TRIM;
    end else if (soft_reset_reg) begin
      trim_reg <= RST_TRIM;                                    // see R06
    end else if (reg_wr_i && reg_addr_i == OFS_TRIM) begin
      trim_reg <= reg_wdata_i;
    end
  end

  assign timer_cfg_o  = timer_reg;
  assign conv_a_cfg_o = conv_a_reg;
  assign conv_b_cfg_o = conv_b_reg;

  // --------------------------------------------------------------------------
  // Front-end decode.
  // --------------------------------------------------------------------------

  assign amp_gain_select      = trim_reg[GAIN_LSB +: 2];
  assign bandpass_pole_select = trim_reg[POLE_LSB +: 2];

  // Decoded selects are registered so the analog side sees clean levels.
  // Code 3 of the gain field is unused and falls to 50 kohm, the smallest
  // resistor, which is the safe side against saturating the amplifier.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fb_200k_o        <= 1'b1;
      fb_100k_o        <= 1'b0;
      fb_50k_o         <= 1'b0;
      pole_low_100k_o  <= 1'b1;
      pole_high_300k_o <= 1'b0;
      amp_reference_select_o <= 2'h0;
    end else begin
      fb_200k_o        <= (amp_gain_select == GAIN_200K);     // see R07
      fb_100k_o        <= (amp_gain_select == GAIN_100K);     // see R07
      fb_50k_o         <= amp_gain_select[1];                 // see R07
      // Bit 1 moves the low pole to 100 kHz, bit 0 the high one to 300 kHz.
      pole_low_100k_o  <= bandpass_pole_select[1];            // see R08
      pole_high_300k_o <= bandpass_pole_select[0];            // see R08
      amp_reference_select_o <= trim_reg[VREF_LSB +: 2];
    end
  end

  // --------------------------------------------------------------------------
  // Read path.
  // --------------------------------------------------------------------------

  // Unmapped addresses read as zero; writes to read-only words are ignored.
  always_comb begin
    case (reg_addr_i)
      OFS_GEST_X1:   read_next = rif.value[0];                 // see R01
      OFS_GEST_X2:   read_next = rif.value[1];                 // see R01
      OFS_GEST_Y1:   read_next = rif.value[2];                 // see R01
      OFS_GEST_Y2:   read_next = rif.value[3];                 // see R01
      OFS_PROX_I:    read_next = rif.value[4];                 // see R02
      OFS_PROX_X:    read_next = rif.value[5];                 // see R02
      OFS_PROX_Y:    read_next = rif.value[6];                 // see R02
      OFS_RESERVED7: read_next = RST_RESERVED7;                // see R10
      OFS_IDENT:     read_next = {VERSION, PART_ID};           // see R03
      OFS_BUS_ADDR:  read_next = {9'h000, BUS_ADDR_WIRE[7:1]}; // see R04
      OFS_OSC_CAL:   read_next = {4'h0, osc_count};            // see R05
      OFS_TIMER:     read_next = timer_reg;
      OFS_SOFT_RST:  read_next = {15'h0000, soft_reset_reg};  // see R12
      OFS_CONV_A:    read_next = conv_a_reg;
      OFS_CONV_B:    read_next = conv_b_reg;
      OFS_TRIM:      read_next = trim_reg;
      default:       read_next = 16'h0000;
    endcase
  end

  // Read data is captured one cycle after the strobe and then held.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= read_next;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence read_at_s(osr_addr_t a);
    reg_rd_i && (reg_addr_i == a);
  endsequence

  sequence soft_req_s;
    reg_wr_i && (reg_addr_i == OFS_SOFT_RST) && reg_wdata_i[SOFT_RST_BIT];
  endsequence

  gesture_clear_a: assert property (soft_reset_reg |=>     // see R01
    rif.value[0] == RST_RESULT && rif.value[1] == RST_RESULT &&
    rif.value[2] == RST_RESULT && rif.value[3] == RST_RESULT)
    else $error("Gesture results not cleared by soft reset.");

  prox_read_a: assert property (read_at_s(OFS_PROX_Y) |=>  // see R02
    reg_rvalid_o && reg_rdata_o == $past(rif.value[6]))
    else $error("Proximity Y read returned wrong value.");

  ident_read_a: assert property (read_at_s(OFS_IDENT) |=>  // see R03
    reg_rdata_o == {VERSION, PART_ID})
    else $error("Identity word read wrong.");

  bus_addr_a: assert property (read_at_s(OFS_BUS_ADDR) |=> // see R04
    reg_rdata_o == {9'h000, BUS_ADDR_WIRE[7:1]})
    else $error("Bus address word read wrong.");

  osc_read_a: assert property (read_at_s(OFS_OSC_CAL) |=>  // see R05
    reg_rdata_o == {4'h0, $past(osc_count)})
    else $error("Calibration count read wrong.");

  soft_pulse_a: assert property (soft_req_s ##1 !reg_wr_i |-> // see R06
    soft_reset_o ##1 !soft_reset_o)
    else $error("Soft reset pulse shape wrong.");

  soft_defaults_a: assert property (soft_reset_o |=>        // see R12
    trim_reg == RST_TRIM && conv_a_reg == RST_CONV_A &&
    (soft_reset_o == $past(soft_hit)))
    else $error("Soft reset did not restore defaults.");

  gain_decode_a: assert property (1'b1 |=>                 // see R07
    fb_200k_o == ($past(amp_gain_select) == GAIN_200K) &&
    fb_50k_o == $past(amp_gain_select[1]))
    else $error("Gain select decode wrong.");

  pole_decode_a: assert property (1'b1 |=>                 // see R08
    {pole_low_100k_o, pole_high_300k_o} == $past(bandpass_pole_select))
    else $error("Pole select decode wrong.");

  reserved_read_a: assert property (read_at_s(OFS_RESERVED7) |=> // see R10
    reg_rdata_o == RST_RESERVED7)
    else $error("Reserved word seven read wrong.");

  // Result reads look one cycle after the strobe, where the registered
  // data stands, against the value held at the strobe.
  gesture_read_a: assert property (read_at_s(OFS_GEST_X1) |=> // see R01
    reg_rdata_o == $past(rif.value[0]))
    else $error("Gesture X first read returned wrong value.");

  // Outside the pulse the soft reset bit must read back as zero.
  soft_read_a: assert property (                            // see R12
    read_at_s(OFS_SOFT_RST) && !soft_reset_reg |=> reg_rdata_o == 16'h0000)
    else $error("Soft reset bit did not read back as zero.");

  // A trim write outside the soft reset cycle lands whole.
  trim_write_a: assert property (                           // see R07
    reg_wr_i && reg_addr_i == OFS_TRIM && !soft_reset_reg |=>
      trim_reg == $past(reg_wdata_i))
    else $error("Trim word write did not land.");

endmodule : osr_register_map

// ---- verilog/osr_result_bank.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Seven result registers, loaded together and clipped at full scale.
// ----------------------------------------------------------------------------
module osr_result_bank (
  input  wire logic   clock_i,
  input  wire logic   rst_i,
  osr_result_if.bank  rif
);
  import osr_pkg::*;

  // Clip a raw sum to sixteen bits rather than letting it wrap.
  function automatic osr_word_t clip(input osr_raw_t v);
    clip = v[16] ? RESULT_MAX : v[15:0];
  endfunction : clip

  genvar k;
  generate
    for (k = 0; k < RESULT_COUNT; k++) begin : g_res
      // Every register loads on the same slot end, so a read never mixes
      // values from two slots.
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          rif.value[k] <= RST_RESULT;
        end else if (rif.clear) begin
          rif.value[k] <= RST_RESULT;
        end else if (rif.slot_end) begin
          rif.value[k] <= clip(rif.raw[k]);                    // see R11
        end
      end

      slot_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
        rif.slot_end && !rif.clear |=>
          rif.value[k] == clip($past(rif.raw[k])))             // see R11
        else $error("Result not loaded with clipped value.");

      slot_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !rif.slot_end && !rif.clear |=> $stable(rif.value[k])) // see R11
        else $error("Result changed outside a slot end.");
    end
  endgenerate

endmodule : osr_result_bank

// ---- verilog/osr_result_if.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Result path between the register map and the result bank.
// ----------------------------------------------------------------------------
interface osr_result_if;
  logic               slot_end;                         // Slot end pulse.
  logic               clear;                            // Soft reset pulse.
  osr_pkg::osr_raw_t  raw   [osr_pkg::RESULT_COUNT];    // Unclipped sums.
  osr_pkg::osr_word_t value [osr_pkg::RESULT_COUNT];    // Held results.
  modport bank (input slot_end, input clear, input raw, output value);
  modport user (output slot_end, output clear, output raw, input value);
endinterface : osr_result_if
